/* hw/dcm_pkg.sv */
/*
   Constants, field layouts and carrier types for the channel control and
   request multiplexer block. Assumes a 32-bit AXI4-Lite register bus whose
   low twelve address bits are decoded by the block.
*/
// Notes on behaviour
// (R1) destination steps 1/2/4 per item when enabled
// (R2) destination fixed when its step is off
// (R3) trigger 0 starts at once, 1 waits request
// (R4) interrupt raised only while interrupt enable set
// (R5) width 00 byte, 01 half, 10 word
// (R6) software picks width to suit the peripheral
// (R7) channel off and clock gated while inactive
// (R8) active bit self clears unless circular mode; the code keeps it set only when circular and peripheral trigger are both set
// (R9) read-only item index counts fetched items
// (R10) item index returns to zero at completion
// (R11) addresses formed from index, steps and width
// (R12) four 4-bit selectors serve four channel pairs
// (R13) receive request drives even, transmit odd channel
// (R14) selector codes map peripherals, others reserved
// (R15) lowest selector owns shared code and acknowledges
// (R16) software gives each code one selector only
// (R17) source steps per item when enabled, else fixed
// (R18) circular: index reset, restart automatically; the code restarts only with peripheral trigger, else goes idle
// (R19) length n gives n plus one items
// (R20) interrupt when threshold equals index before increment
// (R21) software avoids reserved width and selector codes
package dcm_pkg;

   localparam int ADDR_W = 12;

   // printed register indices; the byte address is four times the low ten bits of the index
   localparam logic [31:0] IDX_CTRL  = 32'h5000357c;
   localparam logic [31:0] IDX_INDEX = 32'h5000357e;
   localparam logic [31:0] IDX_MUX   = 32'h50003580;

   localparam logic [ADDR_W-1:0] ADR_CTRL  = {IDX_CTRL[9:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADR_INDEX = {IDX_INDEX[9:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADR_MUX   = {IDX_MUX[9:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADR_SRC   = 12'h000;
   localparam logic [ADDR_W-1:0] ADR_DST   = 12'h004;
   localparam logic [ADDR_W-1:0] ADR_LEN   = 12'h008;
   localparam logic [ADDR_W-1:0] ADR_THR   = 12'h00c;

   localparam logic [15:0] CTRL_RESET  = 16'h0000;
   localparam logic [15:0] CTRL_WMASK  = 16'h1fff;
   localparam logic [15:0] MUX_RESET   = 16'h0000;
   localparam logic [15:0] INDEX_RESET = 16'h0000;
   localparam int SEL_W = 4;

   localparam logic [1:0] WIDTH_BYTE = 2'b00;
   localparam logic [1:0] WIDTH_HALF = 2'b01;
   localparam logic [1:0] WIDTH_WORD = 2'b10;

   localparam logic [3:0] SEL_RSV7  = 4'h7;
   localparam logic [3:0] SEL_RSVA  = 4'ha;
   localparam logic [3:0] SEL_RSVB  = 4'hb;
   localparam logic [3:0] SEL_CONV_RX_ONLY = 4'hc;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [2:0] rsvd;
      logic       mem_init;
      logic       idle_mode;
      logic [2:0] prio;
      logic       circular;
      logic       src_addr_step_en;
      logic       dest_addr_step_en;
      logic       periph_trigger_sel;
      logic       irq_en;
      logic [1:0] item_width;
      logic       chan_on;
   } dcm_ctrl_type;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [1:0]  size;
      logic [31:0] wdata;
   } dcm_mem_req_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_READ = 2'b10,
      ST_WRITE = 2'b11
   } dcm_state_type;

endpackage

/* hw/dcm_channel7.sv */
/*
   Channel 7 control, item index and address generation, plus the request
   multiplexer that routes peripheral request pairs to all eight channels
   and their acknowledges back. Assumes one clock, an AXI4-Lite master,
   a single-beat memory port and peripheral request lines on the same clock.
*/
`timescale 1ns/1ps
module dcm_channel7
   import dcm_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  reset,
   input  wire logic                  s_axi_awvalid,
   output      logic                  s_axi_awready,
   input  wire logic [31:0]           s_axi_awaddr,
   input  wire logic                  s_axi_wvalid,
   output      logic                  s_axi_wready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   output      logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   output      logic [1:0]            s_axi_bresp,
   input  wire logic                  s_axi_arvalid,
   output      logic                  s_axi_arready,
   input  wire logic [31:0]           s_axi_araddr,
   output      logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output      logic [31:0]           s_axi_rdata,
   output      logic [1:0]            s_axi_rresp,
   output      dcm_mem_req_type       mem_req,
   input  wire logic                  mem_ready,
   input  wire logic [31:0]           mem_rdata,
   input  wire logic [15:0]           periph_rx_req,
   input  wire logic [15:0]           periph_tx_req,
   output      logic [15:0]           periph_rx_ack,
   output      logic [15:0]           periph_tx_ack,
   output      logic [6:0]            chan_req,
   input  wire logic [6:0]            chan_ack,
   output      logic                  chan7_clk_en,
   output      logic                  chan7_irq
);

   dcm_ctrl_type    ctrl_r;
   logic [15:0]     mux_r;
   logic [15:0]     index_r;
   logic [15:0]     index_nxt;
   logic [15:0]     len_r;
   logic [15:0]     thr_r;
   logic [31:0]     src_base_r;
   logic [31:0]     dst_base_r;
   logic [31:0]     data_r;
   dcm_state_type   state_r;
   dcm_state_type   state_nxt;
   dcm_mem_req_type mem_r;
   logic            irq_r;
   logic            item_done;
   logic            last_item;
   logic            hw_off;
   logic            chan7_ack;
   logic [7:0]      req_all;
   logic [7:0]      ack_all;

   logic            aw_full_r;
   logic [11:0]     aw_addr_r;
   logic            w_full_r;
   logic [31:0]     w_data_r;
   logic [3:0]      w_strb_r;
   logic            bvalid_r;
   logic [1:0]      bresp_r;
   logic            rvalid_r;
   logic [31:0]     rdata_r;
   logic [1:0]      rresp_r;
   logic            do_write;

   // byte-lane merge of a write into an existing word
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   // byte offset of an item from its index and width
   function automatic logic [31:0] item_offset(input logic [15:0] idx,
                                               input logic [1:0]  w);
      logic [31:0] res;
      res = {16'h0000, idx};
      unique case (w)
         WIDTH_BYTE: res = {16'h0000, idx};                  // R5
         WIDTH_HALF: res = {15'h0000, idx, 1'b0};            // R5
         WIDTH_WORD: res = {14'h0000, idx, 2'b00};           // R5
         default:    res = {14'h0000, idx, 2'b00};           // R21
      endcase
      return res;
   endfunction

   // selector code carries a receive request
   function automatic logic code_valid(input logic [3:0] c);
      return (c != SEL_RSV7) && (c != SEL_RSVA) && (c != SEL_RSVB) &&
             (c < 4'hd);                                      // R14
   endfunction

   // selector code carries a transmit request as well
   function automatic logic code_has_tx(input logic [3:0] c);
      return code_valid(c) && (c != SEL_CONV_RX_ONLY);        // R14
   endfunction

   assign do_write      = aw_full_r && w_full_r && !bvalid_r;
   assign s_axi_awready = !aw_full_r && !bvalid_r;
   assign s_axi_wready  = !w_full_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // write address and data are taken independently and held until both
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         aw_full_r <= 1'b0;
         aw_addr_r <= 12'h000;
         w_full_r  <= 1'b0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr[11:0];
         end
         else if (do_write)
         begin
            aw_full_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         else if (do_write)
         begin
            w_full_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_r <= 1'b1;
         bresp_r  <= (aw_addr_r == ADR_CTRL || aw_addr_r == ADR_INDEX ||
                      aw_addr_r == ADR_MUX || aw_addr_r == ADR_SRC ||
                      aw_addr_r == ADR_DST || aw_addr_r == ADR_LEN ||
                      aw_addr_r == ADR_THR) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= RESP_OKAY;
         unique case (s_axi_araddr[11:0])
            ADR_CTRL:  rdata_r <= {16'h0000, ctrl_r};
            ADR_INDEX: rdata_r <= {16'h0000, index_r};       // R9
            ADR_MUX:   rdata_r <= {16'h0000, mux_r};
            ADR_SRC:   rdata_r <= src_base_r;
            ADR_DST:   rdata_r <= dst_base_r;
            ADR_LEN:   rdata_r <= {16'h0000, len_r};
            ADR_THR:   rdata_r <= {16'h0000, thr_r};
            default:
            begin
               rdata_r <= 32'h0000_0000;
               rresp_r <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
      begin
         rvalid_r <= 1'b0;
      end
   end

   // plain software registers
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         mux_r      <= MUX_RESET;
         len_r      <= 16'h0000;
         thr_r      <= 16'h0000;
         src_base_r <= 32'h0000_0000;
         dst_base_r <= 32'h0000_0000;
      end
      else if (do_write)
      begin
         unique case (aw_addr_r)
            ADR_MUX: mux_r      <= 16'(merge({16'h0000, mux_r}, w_data_r,
                                             w_strb_r)); // R12
            ADR_LEN: len_r      <= 16'(merge({16'h0000, len_r}, w_data_r,
                                             w_strb_r));
            ADR_THR: thr_r      <= 16'(merge({16'h0000, thr_r}, w_data_r,
                                             w_strb_r));
            ADR_SRC: src_base_r <= merge(src_base_r, w_data_r, w_strb_r);
            ADR_DST: dst_base_r <= merge(dst_base_r, w_data_r, w_strb_r);
            default: ;
         endcase
      end
   end

   // control: a software write in the same cycle as completion wins
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ctrl_r <= CTRL_RESET;
      end
      else if (do_write && aw_addr_r == ADR_CTRL)
      begin
         ctrl_r <= 16'(merge({16'h0000, ctrl_r}, w_data_r, w_strb_r)) &
                   CTRL_WMASK;                                // R7
      end
      else if (hw_off)
      begin
         ctrl_r.chan_on <= 1'b0;                              // R8
      end
   end

   assign chan7_clk_en = ctrl_r.chan_on;                      // R7
   assign last_item    = (index_r == len_r);                  // R19
   assign item_done    = (state_r == ST_WRITE) && mem_ready;
   assign hw_off       = item_done && last_item &&
                         !(ctrl_r.circular && ctrl_r.periph_trigger_sel); // R8

   always_comb
   begin
      state_nxt = state_r;
      index_nxt = index_r;
      unique case (state_r)
         ST_IDLE:
         begin
            if (ctrl_r.chan_on)
            begin
               state_nxt = ctrl_r.periph_trigger_sel ? ST_WAIT : ST_READ; // R3
            end
         end
         ST_WAIT:
         begin
            if (!ctrl_r.chan_on)
            begin
               state_nxt = ST_IDLE;
            end
            else if (req_all[7])
            begin
               state_nxt = ST_READ;                           // R3
            end
         end
         ST_READ:
         begin
            if (mem_ready)
            begin
               state_nxt = ST_WRITE;
            end
         end
         ST_WRITE:
         begin
            if (mem_ready)
            begin
               if (last_item)
               begin
                  index_nxt = INDEX_RESET;                    // R10
               end
               else
               begin
                  index_nxt = index_r + 16'h0001;             // R9
               end
               if (hw_off || !ctrl_r.chan_on)
               begin
                  state_nxt = ST_IDLE;
               end
               else
               begin
                  state_nxt = ctrl_r.periph_trigger_sel ? ST_WAIT : ST_READ; // R18
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state_r <= ST_IDLE;
         index_r <= INDEX_RESET;
      end
      else
      begin
         state_r <= state_nxt;
         index_r <= index_nxt;                                // R18
      end
   end

   // bus request carries the address of the next cycle
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         mem_r  <= '0;
         data_r <= 32'h0000_0000;
      end
      else
      begin
         mem_r.valid <= (state_nxt == ST_READ) || (state_nxt == ST_WRITE);
         mem_r.write <= (state_nxt == ST_WRITE);
         mem_r.size  <= ctrl_r.item_width;                    // R5
         if (state_r == ST_READ && mem_ready)
         begin
            data_r      <= mem_rdata;
            mem_r.wdata <= mem_rdata;
         end
         if (state_nxt == ST_READ)
         begin
            mem_r.addr <= src_base_r + (ctrl_r.src_addr_step_en ?
                          item_offset(index_nxt, ctrl_r.item_width) :
                          32'h0000_0000);                     // R17 R11
         end
         else if (state_nxt == ST_WRITE)
         begin
            mem_r.addr <= dst_base_r + (ctrl_r.dest_addr_step_en ?
                          item_offset(index_nxt, ctrl_r.item_width) :
                          32'h0000_0000);                     // R1 R2 R11
         end
      end
   end

   assign mem_req = mem_r;

   // interrupt pulse after an item, compared before the index steps
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= item_done && (thr_r == index_r) && ctrl_r.irq_en; // R20 R4
      end
   end

   assign chan7_irq = irq_r;
   assign chan7_ack = item_done && ctrl_r.periph_trigger_sel;
   assign ack_all   = {chan7_ack, chan_ack};
   assign chan_req  = req_all[6:0];

   genvar k;
   genvar p;
   generate
      for (k = 0; k < 4; k++)
      begin : g_pair
         logic [3:0] sel;
         assign sel = mux_r[SEL_W*k +: SEL_W];                // R12
         assign req_all[2*k]   = code_valid(sel) && periph_rx_req[sel];  // R13
         assign req_all[2*k+1] = code_has_tx(sel) && periph_tx_req[sel]; // R13
      end
      for (p = 0; p < 16; p++)
      begin : g_periph
         always_comb
         begin
            periph_rx_ack[p] = 1'b0;
            periph_tx_ack[p] = 1'b0;
            for (int j = 3; j >= 0; j--)
            begin
               if (mux_r[SEL_W*j +: SEL_W] == 4'(p) && code_valid(4'(p)))
               begin
                  periph_rx_ack[p] = ack_all[2*j];            // R15
                  periph_tx_ack[p] = code_has_tx(4'(p)) && ack_all[2*j+1]; // R15
               end
            end
         end
      end
   endgenerate

endmodule

/* test/dcm_mem_model.sv */
/*
   dcm_mem_model: single-beat memory answering the engine's requests.
   Assumes the request is held until mem_ready; slow adds three wait cycles.
*/
`timescale 1ns/1ps
module dcm_mem_model
   import dcm_pkg::*;
(
   input  wire logic            mclk,
   input  wire logic            reset,
   input  wire dcm_mem_req_type mem_req,
   input  wire logic            slow,
   output      logic            mem_ready,
   output      logic [31:0]     mem_rdata
);
   logic [2:0]  wait_r;
   logic [31:0] junk_r;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         wait_r <= 3'h0;
         junk_r <= 32'h0;
      end
      else
      begin
         junk_r <= junk_r + 32'h9e37_79b9;
         if (!mem_req.valid || mem_ready)
            wait_r <= 3'h0;
         else
            wait_r <= wait_r + 3'h1;
      end
   end

   assign mem_ready = mem_req.valid && (!slow || wait_r == 3'h3);
   // read data only valid in the ready cycle; otherwise a moving pattern
   assign mem_rdata = mem_ready ? (mem_req.addr ^ 32'ha5a5_0000) : junk_r;
endmodule

/* test/dcm_checker.sv */
/*
   dcm_checker: assertions on the ports of dcm_channel7.
   Assumes one clock mclk and asynchronous active-high reset.
*/
`timescale 1ns/1ps
module dcm_checker
   import dcm_pkg::*;
(
   input  wire logic            mclk,
   input  wire logic            reset,
   input  wire logic            s_axi_awready,
   input  wire logic            s_axi_wready,
   input  wire logic            s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [1:0]      s_axi_bresp,
   input  wire logic            s_axi_arvalid,
   input  wire logic            s_axi_arready,
   input  wire logic            s_axi_rvalid,
   input  wire logic            s_axi_rready,
   input  wire logic [31:0]     s_axi_rdata,
   input  wire dcm_mem_req_type mem_req,
   input  wire logic            mem_ready,
   input  wire logic [31:0]     mem_rdata,
   input  wire logic            chan7_clk_en,
   input  wire logic            chan7_irq
);
   logic item_done_r;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         item_done_r <= 1'b0;
      else
         item_done_r <= mem_req.valid && mem_req.write && mem_ready;
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not returned");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   beat_hold_a: assert property (mem_req.valid && !mem_ready |=> $stable(mem_req))
      else $error("memory beat changed before ready");
   store_after_a: assert property (mem_req.valid && !mem_req.write && mem_ready |=>
      mem_req.valid && mem_req.write && mem_req.size == $past(mem_req.size))
      else $error("store beat missing after fetch");
   data_pass_a: assert property (mem_req.valid && !mem_req.write && mem_ready |=>
      mem_req.wdata == $past(mem_rdata))
      else $error("stored data differs from fetched");
   irq_cause_a: assert property (chan7_irq |-> item_done_r)
      else $error("interrupt without finished item");
   enable_write_a: assert property ($rose(chan7_clk_en) |-> ##[0:1] s_axi_bvalid)
      else $error("channel enabled without write");
   idle_quiet_a: assert property (!chan7_clk_en && !mem_req.valid |=> !mem_req.valid)
      else $error("beat started while channel off");

   cover property (mem_req.valid && mem_req.write && mem_ready);
   cover property (chan7_irq);
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

/* test/dcm_channel7_tb.sv */
/*
   dcm_channel7_tb: register, request routing and transfer tests.
   Assumes dcm_mem_model as memory; the bench plays the peripherals.
*/
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         error_cnt++; \
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
      end \
   end
module dcm_channel7_tb
   import dcm_pkg::*;
;
   logic            mclk, reset, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic            s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic            s_axi_arready, s_axi_rvalid, s_axi_rready, mem_ready;
   logic            chan7_clk_en, chan7_irq, rx_ok, tx_ok, sst, dst_st, ien;
   logic [31:0]     s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, mem_rdata;
   logic [31:0]     step, srca, dsta;
   logic [3:0]      s_axi_wstrb;
   logic [1:0]      s_axi_bresp, s_axi_rresp, wd;
   logic [15:0]     periph_rx_req, periph_tx_req, periph_rx_ack, periph_tx_ack, sel;
   logic [6:0]      chan_req, chan_ack;
   logic [7:0]      exp8;
   dcm_mem_req_type mem_req;
   logic [66:0]     beats[$];
   logic [3:0]      codes[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                                  4'h8, 4'h9, 4'ha, 4'hc};
   int              error_cnt = 0;
   int              samples_checked = 0;
   int              cyc = 0;
   int              irq_cnt = 0;
   int              ack_cnt = 0;

   dcm_channel7 dcm_channel7_i (.*);

   dcm_mem_model dcm_mem_model_i (.*);

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic complete_run();
      begin
         if (error_cnt == 0 && samples_checked > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_done;
      logic w_done;
      begin
         aw_done = 1'b0;
         w_done = 1'b0;
         s_axi_awaddr <= {20'h0, a};
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         while (!(aw_done && w_done))
         begin
            @(posedge mclk);
            if (!aw_done && s_axi_awready)
            begin
               aw_done = 1'b1;
               s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready)
            begin
               w_done = 1'b1;
               s_axi_wvalid <= 1'b0;
            end
         end
         do @(posedge mclk); while (!s_axi_bvalid);
         `CHK(s_axi_bresp, er)
      end
   endtask

   task automatic axi_rd(input logic [11:0] a, input logic [31:0] ex, input logic [1:0] er);
      begin
         s_axi_araddr <= {20'h0, a};
         s_axi_arvalid <= 1'b1;
         do @(posedge mclk); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         do @(posedge mclk); while (!s_axi_rvalid);
         `CHK(s_axi_rdata, ex)
         `CHK(s_axi_rresp, er)
      end
   endtask

   // beat log: {write, size, addr, wdata}
   always @(posedge mclk)
   begin
      cyc++;
      if (mem_req.valid && mem_ready)
         beats.push_back({mem_req.write, mem_req.size, mem_req.addr, mem_req.wdata});
      if (chan7_irq)
         irq_cnt++;
      if (periph_tx_ack[2])
         ack_cnt++;
      if (cyc == 20000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   initial
   begin
      reset = 1'b1;
      slow = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      {periph_rx_req, periph_tx_req, chan_ack} = 39'h0;
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      axi_rd(ADR_CTRL, {16'h0, CTRL_RESET}, RESP_OKAY);
      axi_rd(ADR_INDEX, {16'h0, INDEX_RESET}, RESP_OKAY);
      axi_rd(ADR_MUX, {16'h0, MUX_RESET}, RESP_OKAY);
      axi_wr(ADR_INDEX, 32'h0000_1234, RESP_OKAY);
      axi_rd(ADR_INDEX, 32'h0, RESP_OKAY);
      axi_wr(12'h100, 32'h1, RESP_SLVERR);
      axi_rd(12'h100, 32'h0, RESP_SLVERR);
      axi_wr(ADR_MUX, 32'hffff_c985, RESP_OKAY);
      axi_rd(ADR_MUX, 32'h0000_c985, RESP_OKAY);
      axi_wr(ADR_CTRL, 32'hffff_fffe, RESP_OKAY);
      axi_rd(ADR_CTRL, {16'h0, CTRL_WMASK & 16'hfffe}, RESP_OKAY);
      // codes 0 to a and c on every selector, the rest parked on reserved code 7
      for (int p = 0; p < 4; p++)
         for (int c = 0; c < 12; c++)
         begin
            sel = 16'h7777;
            sel[4*p +: 4] = codes[c];
            axi_wr(ADR_MUX, {16'h0, sel}, RESP_OKAY);
            periph_rx_req <= 16'h1 << codes[c];
            periph_tx_req <= 16'h1 << codes[c];
            chan_ack <= 7'h7f;
            @(posedge mclk);
            rx_ok = !(codes[c] inside {4'h7, 4'ha});
            tx_ok = rx_ok && codes[c] != 4'hc;
            exp8 = 8'h0;
            exp8[2*p] = rx_ok;
            exp8[2*p+1] = tx_ok;
            `CHK(chan_req, exp8[6:0])
            `CHK(periph_rx_ack, rx_ok ? 16'h1 << codes[c] : 16'h0)
            `CHK(periph_tx_ack, (tx_ok && p < 3) ? 16'h1 << codes[c] : 16'h0)
         end
      axi_wr(ADR_MUX, 32'h0000_2222, RESP_OKAY);
      periph_rx_req <= 16'h0004;
      periph_tx_req <= 16'h0004;
      chan_ack <= 7'h0c;
      @(posedge mclk);
      `CHK({periph_rx_ack, periph_tx_ack}, 32'h0)
      chan_ack <= 7'h03;
      @(posedge mclk);
      `CHK({periph_rx_ack, periph_tx_ack}, 32'h0004_0004)
      {periph_rx_req, periph_tx_req, chan_ack} <= 39'h0;
      axi_wr(ADR_SRC, 32'h0000_1000, RESP_OKAY);
      axi_wr(ADR_DST, 32'h0000_2000, RESP_OKAY);
      axi_wr(ADR_LEN, 32'h2, RESP_OKAY);
      axi_wr(ADR_THR, 32'h1, RESP_OKAY);
      for (int k = 0; k < 4; k++)
      begin
         wd = (k == 3) ? WIDTH_WORD : 2'(k);
         sst = (k != 3);
         dst_st = (k != 1);
         ien = (k % 2 == 0);
         step = 32'h1 << wd;
         slow <= (k % 2 == 1);
         beats.delete();
         irq_cnt = 0;
         axi_wr(ADR_CTRL, {25'h0, sst, dst_st, 1'b0, ien, wd, 1'b1}, RESP_OKAY);
         `CHK(chan7_clk_en, 1'b1)
         while (chan7_clk_en)
            @(posedge mclk);
         repeat (3) @(posedge mclk);
         `CHK(beats.size(), 6)
         for (int i = 0; i < 6 && i < beats.size(); i++)
         begin
            srca = 32'h1000 + (sst ? 32'(i / 2) * step : 32'h0);
            dsta = 32'h2000 + (dst_st ? 32'(i / 2) * step : 32'h0);
            `CHK(beats[i][66:32], {i[0], wd, i[0] ? dsta : srca})
            if (i[0])
               `CHK(beats[i][31:0], srca ^ 32'ha5a5_0000)
         end
         `CHK(irq_cnt, ien ? 1 : 0)
         axi_rd(ADR_INDEX, 32'h0, RESP_OKAY);
         axi_rd(ADR_CTRL, {25'h0, sst, dst_st, 1'b0, ien, wd, 1'b0}, RESP_OKAY);
      end
      // peripheral-triggered circular run on the odd channel of pair 6/7
      axi_wr(ADR_MUX, 32'h0000_2000, RESP_OKAY);
      axi_wr(ADR_LEN, 32'h0, RESP_OKAY);
      slow <= 1'b0;
      beats.delete();
      ack_cnt = 0;
      axi_wr(ADR_CTRL, 32'h0000_0091, RESP_OKAY);
      repeat (20) @(posedge mclk);
      `CHK(beats.size(), 0)
      periph_tx_req <= 16'h0004;
      while (beats.size() < 2)
         @(posedge mclk);
      periph_tx_req <= 16'h0;
      repeat (6) @(posedge mclk);
      `CHK(beats[0][66:32], {1'b0, WIDTH_BYTE, 32'h1000})
      `CHK(ack_cnt > 0, 1'b1)
      `CHK(chan7_clk_en, 1'b1)
      axi_rd(ADR_INDEX, 32'h0, RESP_OKAY);
      axi_wr(ADR_CTRL, 32'h0, RESP_OKAY);
      repeat (8) @(posedge mclk);
      `CHK(chan7_clk_en, 1'b0)
      complete_run();
   end
endmodule

bind dcm_channel7 dcm_checker dcm_checker_i (.*);
